/* verilog/brht_timing.sv */
// brht_timing: serial clock and hold-time sequencer with its divider register.
// assumes i_scl_i and i_sda_i are already synchronous to i_clk; open-drain pads
// are resolved outside from the output enables.
`timescale 1ns/100ps

// How it works
// - multiplier code 00 gives x1, 01 gives x2, 10 gives x4, and 11 is reserved and refused.
// - the serial clock period is the bus clock period times multiplier times the indexed divider.
// - after each clock fall the data line changes only after bus period x mul x data-hold value.
// - a start pulls data low with clock high, then holds the clock high for mul x start-hold.
// - a stop releases the clock first, then waits mul x stop-hold before releasing data.
// - the divider register is read/write and clears to 00h on reset.
module brht_timing
  import brht_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_scl_i,
  output logic                   o_scl_o,
  output logic                   o_scl_oe,
  input  wire logic              i_sda_i,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  output logic                   o_busy
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  brht_state_t       state_reg;
  brht_state_t       state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              scl_oe_reg;
  logic              scl_oe_next;
  logic              sda_oe_reg;
  logic              sda_oe_next;
  logic              stop_reg;
  logic              stop_next;
  logic              tx_reg;
  logic              tx_next;
  logic              rx_reg;
  logic              rx_next;
  logic              refused_reg;
  logic [DATA_W-1:0] div_reg;
  logic [DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire              div_wr    = i_wr && (i_addr == DIV_OFFSET);
  wire              ctrl_wr   = i_wr && (i_addr == CTRL_OFFSET);
  wire              status_wr = i_wr && (i_addr == STATUS_OFFSET);
  wire [1:0]        rate_multiplier_select      = div_reg[RATE_MULTIPLIER_SELECT_MSB:RATE_MULTIPLIER_SELECT_LSB];
  wire [IDX_W-1:0]  idx       = div_reg[IDX_MSB:0];
  wire              rate_multiplier_select_bad  = (rate_multiplier_select == RATE_MULTIPLIER_SELECT_RSVD);
  wire              idle      = (state_reg == BRHT_IDLE);
  wire              cmd_start = ctrl_wr && i_wdata[CTRL_START_BIT];
  wire              cmd_stop  = ctrl_wr && i_wdata[CTRL_STOP_BIT];
  wire              cmd_xfer  = ctrl_wr && i_wdata[CTRL_XFER_BIT];
  wire              cmd_any   = cmd_start || cmd_stop || cmd_xfer;
  // start needs a free clock, bit and stop need the clock held low by us
  wire              ok_base   = idle && !rate_multiplier_select_bad;
  wire              start_ok  = ok_base && cmd_start && !cmd_stop && !cmd_xfer && !scl_oe_reg;
  wire              stop_ok   = ok_base && cmd_stop && !cmd_start && !cmd_xfer && scl_oe_reg;
  wire              xfer_ok   = ok_base && cmd_xfer && !cmd_start && !cmd_stop && scl_oe_reg;
  // a refused command only sets the sticky status bit; the lines stay as they are
  // the reserved code is still storable so software reads back what it wrote
  wire              refuse    = cmd_any && !(start_ok || stop_ok || xfer_ok);

  wire [DATA_W-1:0] status_val = {3'h0, scl_oe_reg, refused_reg, rx_reg, rate_multiplier_select_bad, !idle};
  wire [DATA_W-1:0] rd_mux     = (i_addr == DIV_OFFSET)    ? div_reg :
                                 (i_addr == STATUS_OFFSET) ? status_val : 8'h00;

  // ----------------------------------------------------------------
  // lookup table and cycle counts
  // ----------------------------------------------------------------
  // table is linear in the index; swap these four lines for a real table
  wire [CNT_W-1:0] idx_w      = {10'h000, idx};
  wire [CNT_W-1:0] idx_hi     = {12'h000, idx[IDX_MSB:2]};
  wire [CNT_W-1:0] scl_div    = SCL_DIV_BASE + (SCL_DIV_STEP * idx_w);
  wire [CNT_W-1:0] sda_hold   = SDA_HOLD_BASE + idx_hi;
  wire [CNT_W-1:0] start_hold = START_HOLD_BASE + idx_hi;
  wire [CNT_W-1:0] stop_hold  = STOP_HOLD_BASE + idx_hi;

  // the multiplier code is also the shift count: 0, 1 or 2, giving x1, x2 or x4
  wire [CNT_W-1:0] period_cyc = scl_div << rate_multiplier_select;
  wire [CNT_W-1:0] sda_cyc    = sda_hold << rate_multiplier_select;
  wire [CNT_W-1:0] start_cyc  = start_hold << rate_multiplier_select;
  wire [CNT_W-1:0] stop_cyc   = stop_hold << rate_multiplier_select;
  wire [CNT_W-1:0] half_cyc   = period_cyc >> 1;
  wire [CNT_W-1:0] high_cyc   = period_cyc - half_cyc;
  // a long data hold stretches the low phase instead of being cut short
  wire [CNT_W-1:0] low_cyc    = (half_cyc > sda_cyc) ? half_cyc : sda_cyc + 16'h0001;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one counter serves every phase and restarts at zero on each change;
  // comparing against count-1 makes a phase last exactly its count
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg + 16'h0001;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    stop_next   = stop_reg;
    tx_next     = tx_reg;
    rx_next     = rx_reg;
    case (state_reg)
      BRHT_IDLE: begin
        cnt_next = '0;
        if (start_ok) begin
          sda_oe_next = 1'b1;
          state_next  = BRHT_START_HOLD;
        end else if (stop_ok || xfer_ok) begin
          stop_next  = stop_ok;
          tx_next    = i_wdata[CTRL_TXVAL_BIT];
          state_next = BRHT_LOW;
        end
      end
      BRHT_START_HOLD: begin
        if (cnt_reg >= start_cyc - 16'h0001) begin
          scl_oe_next = 1'b1;
          cnt_next    = '0;
          state_next  = BRHT_IDLE;
        end
      end
      BRHT_LOW: begin
        if (cnt_reg == sda_cyc - 16'h0001) begin
          sda_oe_next = stop_reg || !tx_reg;
        end
        if (cnt_reg >= low_cyc - 16'h0001) begin
          scl_oe_next = 1'b0;
          cnt_next    = '0;
          state_next  = stop_reg ? BRHT_STOP_HOLD : BRHT_HIGH;
        end
      end
      BRHT_HIGH: begin
        // another master stretching the clock freezes the count
        if (!i_scl_i) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg >= high_cyc - 16'h0001) begin
          rx_next     = i_sda_i;
          scl_oe_next = 1'b1;
          cnt_next    = '0;
          state_next  = BRHT_IDLE;
        end
      end
      BRHT_STOP_HOLD: begin
        if (!i_scl_i) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg >= stop_cyc - 16'h0001) begin
          sda_oe_next = 1'b0;
          cnt_next    = '0;
          state_next  = BRHT_IDLE;
        end
      end
      default: begin
        cnt_next    = '0;
        scl_oe_next = 1'b0;
        sda_oe_next = 1'b0;
        state_next  = BRHT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg  <= BRHT_IDLE;
      cnt_reg    <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      stop_reg   <= 1'b0;
      tx_reg     <= 1'b0;
      rx_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      stop_reg   <= stop_next;
      tx_reg     <= tx_next;
      rx_reg     <= rx_next;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // divider writes apply at once, even in mid-sequence
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_reg <= DIV_RESET;
    end else if (div_wr) begin
      div_reg <= i_wdata;
    end
  end

  // set wins over the write-one clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      refused_reg <= 1'b0;
    end else if (refuse) begin
      refused_reg <= 1'b1;
    end else if (status_wr && i_wdata[ST_REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_rd ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain pads: the value is always low, the enables do the work
  assign o_rdata  = rdata_reg;
  assign o_scl_o  = 1'b0;
  assign o_sda_o  = 1'b0;
  assign o_scl_oe = scl_oe_reg;
  assign o_sda_oe = sda_oe_reg;
  assign o_busy   = !idle;

endmodule : brht_timing

/* inc/brht_pkg.sv */
// brht_pkg: constants, register map and state encoding of the i2c bit-rate and hold timer.
// assumes one 100 MHz bus clock and byte-wide register access.
package brht_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned IDX_W  = 6;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DIV_OFFSET    = 8'h01;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h02;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h03;
  localparam logic [DATA_W-1:0] DIV_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned RATE_MULTIPLIER_SELECT_MSB       = 7;
  localparam int unsigned RATE_MULTIPLIER_SELECT_LSB       = 6;
  localparam int unsigned IDX_MSB        = 5;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT  = 1;
  localparam int unsigned CTRL_XFER_BIT  = 2;
  localparam int unsigned CTRL_TXVAL_BIT = 3;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_MULTBAD_BIT = 1;
  localparam int unsigned ST_RXBIT_BIT   = 2;
  localparam int unsigned ST_REFUSED_BIT = 3;
  localparam int unsigned ST_HOLDCLK_BIT = 4;

  // ----------------------------------------------------------------
  // multiplier encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_MULTIPLIER_SELECT_X1   = 2'h0;
  localparam logic [1:0] RATE_MULTIPLIER_SELECT_X2   = 2'h1;
  localparam logic [1:0] RATE_MULTIPLIER_SELECT_X4   = 2'h2;
  localparam logic [1:0] RATE_MULTIPLIER_SELECT_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // lookup table shape, in bus-clock periods before the multiplier
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SCL_DIV_BASE    = 16'h0014;
  localparam logic [CNT_W-1:0] SCL_DIV_STEP    = 16'h0002;
  localparam logic [CNT_W-1:0] SDA_HOLD_BASE   = 16'h0007;
  localparam logic [CNT_W-1:0] START_HOLD_BASE = 16'h0006;
  localparam logic [CNT_W-1:0] STOP_HOLD_BASE  = 16'h000b;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BRHT_IDLE       = 3'b000,
    BRHT_START_HOLD = 3'b001,
    BRHT_LOW        = 3'b010,
    BRHT_HIGH       = 3'b011,
    BRHT_STOP_HOLD  = 3'b100
  } brht_state_t;

endpackage : brht_pkg

/* test/brht_timing_asserts.sv */
// brht_timing_asserts: port-level timing checks of the bit-rate and hold timer.
// assumes pad levels are fed back on i_scl_i/i_sda_i.
`timescale 1ns/100ps
module brht_timing_asserts
  import brht_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              i_scl_i,
  input wire logic              o_scl_oe,
  input wire logic              o_sda_oe,
  input wire logic              o_busy
);
  logic [7:0]  div_reg;
  logic [3:0]  cmd_reg;
  logic [15:0] cnt_reg;
  logic [15:0] hcnt_reg;
  wire  [1:0]  code  = div_reg[7:6];
  wire  [15:0] per   = (SCL_DIV_BASE + SCL_DIV_STEP * div_reg[5:0]) << code;
  wire  [15:0] lo    = per >> 1;
  wire  [15:0] hi    = per - lo;
  wire  [15:0] hsda  = (SDA_HOLD_BASE + div_reg[5:2]) << code;
  wire  [15:0] hst   = (START_HOLD_BASE + div_reg[5:2]) << code;
  wire  [15:0] hsp   = (STOP_HOLD_BASE + div_reg[5:2]) << code;
  wire  [15:0] low_t = (lo > hsda) ? lo : hsda + 16'h0001;
  // high-phase count freezes while the far side stretches the clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_reg  <= DIV_RESET;
      cmd_reg  <= 4'h0;
      hcnt_reg <= 16'h0000;
    end else begin
      if (i_wr && i_addr == DIV_OFFSET) div_reg <= i_wdata;
      if (i_wr && i_addr == CTRL_OFFSET && !o_busy) cmd_reg <= i_wdata[3:0];
      hcnt_reg <= o_scl_oe ? 16'h0000 : hcnt_reg + {15'h0000, i_scl_i};
    end
    cnt_reg <= o_busy ? cnt_reg + 16'h0001 : 16'h0000;
  end
  default clocking dclk @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence div_wr_rd;
    i_wr && i_addr == DIV_OFFSET ##1 i_rd && i_addr == DIV_OFFSET;
  endsequence
  AST_RST_QUIET: assert property (
    disable iff (1'b0) i_srst |=> !o_busy && !o_scl_oe && !o_sda_oe && o_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  AST_DIV_RW: assert property (div_wr_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("divider read back differs");
  AST_RSVD_REFUSE: assert property (
    i_wr && i_addr == CTRL_OFFSET && code == RATE_MULTIPLIER_SELECT_RSVD && !o_busy |=> !o_busy [*2])
    else $error("command accepted with reserved multiplier");
  AST_START_HOLD: assert property (
    $rose(o_scl_oe) && cmd_reg[0] |-> cnt_reg == hst && o_sda_oe)
    else $error("start hold length wrong");
  AST_SDA_HOLD: assert property (
    o_busy && $changed(o_sda_oe) && cmd_reg[2:1] != 2'b00 |-> cnt_reg == hsda)
    else $error("data hold length wrong");
  AST_LOW_TIME: assert property ($fell(o_scl_oe) && cmd_reg[2] |-> cnt_reg == low_t)
    else $error("clock low phase wrong");
  AST_HIGH_TIME: assert property (
    $rose(o_scl_oe) && cmd_reg[2] |-> hcnt_reg == hi && !o_busy)
    else $error("clock high phase wrong");
  AST_STOP_HOLD: assert property (
    $fell(o_sda_oe) && cmd_reg[1] |-> hcnt_reg == hsp && !o_scl_oe && !o_busy)
    else $error("stop hold length wrong");
endmodule : brht_timing_asserts

bind brht_timing brht_timing_asserts chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl_i(i_scl_i),
  .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_busy(o_busy));

/* test/brht_line_model.sv */
// brht_line_model: pull-up bus lines with a far-side device that may stretch and drive data.
// assumes the timer's enables pull the lines low.
`timescale 1ns/100ps
module brht_line_model (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_scl_oe,
  input  wire logic i_sda_oe,
  input  wire logic i_slow,
  input  wire logic i_pull_sda,
  output logic      o_scl,
  output logic      o_sda
);
  logic [2:0] hold_reg;
  // slow mode keeps the clock low 5 cycles after every release
  always_ff @(posedge i_clk) begin
    if (i_srst) hold_reg <= 3'h0;
    else if (i_scl_oe) hold_reg <= i_slow ? 3'h5 : 3'h0;
    else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
  end
  assign o_scl = !i_scl_oe && hold_reg == 3'h0;
  assign o_sda = !i_sda_oe && !i_pull_sda;
endmodule : brht_line_model

/* test/brht_timing_bench.sv */
// brht_timing_bench: register and line-sequence stimulus, read data checked from a queue.
// assumes the checker is bound to the timer; line timing is judged there.
`timescale 1ns/100ps
module brht_timing_bench;
  import brht_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_srst, i_wr, i_rd, slow, pull, scl, sda, o_busy, scl_oe, sda_oe, rd_q = 1'b0;
  logic [7:0] i_addr, i_wdata, o_rdata, d, exp_q[$];
  int         error_cnt = 0;
  int         total_checks = 0;
  int         seed = 17;
  always #5 i_clk = ~i_clk;
  brht_timing dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl_i(scl), .o_scl_o(), .o_scl_oe(scl_oe),
    .i_sda_i(sda), .o_sda_o(), .o_sda_oe(sda_oe), .o_busy(o_busy));
  brht_line_model line_u (.i_clk(i_clk), .i_srst(i_srst), .i_scl_oe(scl_oe),
    .i_sda_oe(sda_oe), .i_slow(slow), .i_pull_sda(pull), .o_scl(scl), .o_sda(sda));
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected read data: expected %h seen %h", exp, got);
    end
  endtask : chk
  // read data stands only one cycle after the strobe
  always @(negedge i_clk) begin
    if (rd_q) chk(exp_q.pop_front(), o_rdata);
    rd_q = i_rd;
  end
  task op(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= w;
    i_rd    <= !w;
    i_addr  <= a;
    i_wdata <= v;
    if (!w) exp_q.push_back(v);
  endtask : op
  task quiet;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask : quiet
  task cmd(input logic [7:0] c);
    int n;
    op(1'b1, CTRL_OFFSET, c);
    quiet();
    n = 0;
    @(negedge i_clk);
    while (o_busy === 1'b1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      give_verdict();
    end
  endtask : cmd
  initial begin
    {i_srst, i_wr, i_rd, i_addr, i_wdata, slow, pull} = {1'b1, 20'h00000};
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    op(1'b0, DIV_OFFSET, DIV_RESET);
    op(1'b0, 8'hff, 8'h00);
    op(1'b0, CTRL_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      op(1'b1, DIV_OFFSET, d);
      op(1'b0, DIV_OFFSET, d);
    end
    op(1'b1, DIV_OFFSET, 8'hc0);
    op(1'b1, CTRL_OFFSET, 8'h01);
    op(1'b0, STATUS_OFFSET, 8'h0a);
    op(1'b1, STATUS_OFFSET, 8'h08);
    op(1'b0, STATUS_OFFSET, 8'h02);
    quiet();
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      d = {2'(m), 6'($random(seed))};
      op(1'b1, DIV_OFFSET, d);
      quiet();
      slow <= m[0];
      cmd(8'h01);
      pull <= 1'b1;
      cmd(8'h0c);
      op(1'b0, STATUS_OFFSET, 8'h10);
      quiet();
      pull <= 1'b0;
      cmd(8'h04);
      cmd(8'h0c);
      op(1'b0, STATUS_OFFSET, 8'h14);
      quiet();
      cmd(8'h02);
      $display("test sequence done");
    end
    op(1'b1, CTRL_OFFSET, 8'h04);
    op(1'b0, STATUS_OFFSET, 8'h0c);
    op(1'b1, STATUS_OFFSET, 8'h08);
    op(1'b1, CTRL_OFFSET, 8'h03);
    op(1'b0, STATUS_OFFSET, 8'h0c);
    quiet();
    $display("test refusal done");
    op(1'b1, CTRL_OFFSET, 8'h01);
    @(posedge i_clk);
    i_wr   <= 1'b0;
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    op(1'b0, DIV_OFFSET, 8'h00);
    quiet();
    $display("test reset done");
    give_verdict();
  end
endmodule : brht_timing_bench
